// ===== shared/asram_pkg.sv
// constants for the host controller of an asynchronous 256k x 4 static memory
// assumes a 25 MHz controller clock; the memory itself has no clock
package asram_pkg;
  localparam int unsigned ASRAM_IDX_W = 18;
  localparam int unsigned ASRAM_DAT_W = 4;
  localparam int unsigned ASRAM_WORDS = 262144;
  localparam int unsigned ASRAM_CLK_NS = 40;
  // minimum strobe overlap for a write, output drive held high (ns)
  localparam int unsigned ASRAM_WR_PULSE_NS = 20;
  // minimum strobe overlap for a write, output drive held low (ns)
  localparam int unsigned ASRAM_WR_PULSE_OE_NS = 20;
  // read access allowance from select and output drive (ns)
  localparam int unsigned ASRAM_RD_ACC_NS = 20;
  // bus turnaround gap after the memory stops driving (ns)
  localparam int unsigned ASRAM_TURN_NS = 9;
  localparam logic [3:0] ASRAM_WR_CYC =
    4'((ASRAM_WR_PULSE_NS + ASRAM_CLK_NS - 1) / ASRAM_CLK_NS);
  localparam logic [3:0] ASRAM_WR_OE_CYC =
    4'((ASRAM_WR_PULSE_OE_NS + ASRAM_CLK_NS - 1) / ASRAM_CLK_NS + 1);
  localparam logic [3:0] ASRAM_RD_CYC =
    4'((ASRAM_RD_ACC_NS + ASRAM_CLK_NS - 1) / ASRAM_CLK_NS);
  localparam logic [3:0] ASRAM_TURN_CYC =
    4'((ASRAM_TURN_NS + ASRAM_CLK_NS - 1) / ASRAM_CLK_NS);
  typedef enum logic [2:0] {
    ASRAM_IDLE = 3'b000,
    ASRAM_RD = 3'b001,
    ASRAM_WR_SET = 3'b010,
    ASRAM_WR = 3'b011,
    ASRAM_WR_HOLD = 3'b100,
    ASRAM_TURN = 3'b101
  } asram_state_type;
endpackage : asram_pkg

// ===== shared/asram_tmr_if.sv
// timer handshake between the sequencer and its phase counter
// assumes a single clock domain
`timescale 1ns/1ps
interface asram_tmr_if;
  logic load;
  logic [3:0] count;
  logic done;
  modport seq (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : asram_tmr_if

// ===== design/asram_tmr.sv
// phase counter: loads a cycle count and flags when it has run out
// assumes synchronous active-high reset
`timescale 1ns/1ps
module asram_tmr
  import asram_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  asram_tmr_if.tmr t
);
  logic [3:0] cnt_r;
  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_r <= 4'h0;
    else if (t.load)
      cnt_r <= t.count;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  // done looks at the count alone so the sequencer's load, which depends on done, forms no loop
  assign t.done = (cnt_r == 4'h0);
endmodule : asram_tmr

// ===== design/asram_host.sv
// host controller for an asynchronous 256k x 4 static memory
// assumes req_* held stable while req_valid is high and req_ready low
//
// Function
// - one shared four-bit data bus, one driver
// - write strobe held high during reads
// - index latched on the same edge that select falls
// - never drive data while memory reads
// - sequence strobes to avoid bus contention
`timescale 1ns/1ps
module asram_host
  import asram_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_oe_low,
  input wire logic [ASRAM_IDX_W-1:0] req_index,
  input wire logic [ASRAM_DAT_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [ASRAM_DAT_W-1:0] rsp_rdata,
  output logic [ASRAM_IDX_W-1:0] word_index,
  output logic sel_n,
  output logic wstrobe_n,
  output logic odrive_n,
  output logic [ASRAM_DAT_W-1:0] shared_data_lines_o,
  output logic shared_data_lines_oe_n,
  input wire logic [ASRAM_DAT_W-1:0] shared_data_lines_i
);
  asram_state_type state_r, state_nxt;
  asram_tmr_if tif ();
  logic oe_mode_r;

  asram_tmr u_tmr (
    .mclk(mclk),
    .rst(rst),
    .t(tif.tmr)
  );

  function automatic logic [3:0] wr_len(input logic oe_low);
    wr_len = oe_low ? ASRAM_WR_OE_CYC : ASRAM_WR_CYC;
  endfunction : wr_len

  wire take = req_valid && req_ready;

  always_comb
  begin
    state_nxt = state_r;
    tif.load = 1'b0;
    tif.count = 4'h0;
    case (state_r)
      ASRAM_IDLE:
      begin
        if (take)
        begin
          state_nxt = req_write ? ASRAM_WR_SET : ASRAM_RD;
          tif.load = !req_write;
          tif.count = ASRAM_RD_CYC;
        end
      end
      ASRAM_RD:
      begin
        if (tif.done)
        begin
          state_nxt = ASRAM_TURN;
          tif.load = 1'b1;
          tif.count = ASRAM_TURN_CYC;
        end
      end
      ASRAM_WR_SET:
      begin
        state_nxt = ASRAM_WR;
        tif.load = 1'b1;
        tif.count = wr_len(oe_mode_r);
      end
      ASRAM_WR:
        if (tif.done)
          state_nxt = ASRAM_WR_HOLD;
      ASRAM_WR_HOLD:
        state_nxt = ASRAM_IDLE;
      ASRAM_TURN:
        if (tif.done)
          state_nxt = ASRAM_IDLE;
      default:
        state_nxt = ASRAM_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_r <= ASRAM_IDLE;
    else
      state_r <= state_nxt;
  end

  // address and write data latched on the same edge that select and strobes first move
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      word_index <= '0;
      shared_data_lines_o <= '0;
      oe_mode_r <= 1'b0;
    end
    else if (take)
    begin
      word_index <= req_index;
      shared_data_lines_o <= req_wdata;
      oe_mode_r <= req_write && req_oe_low;
    end
  end

  function automatic logic oe_mode_nxt();
    oe_mode_nxt = (state_r == ASRAM_IDLE) ? (req_write && req_oe_low) : oe_mode_r;
  endfunction : oe_mode_nxt

  // strobes: select is low only in access states, idle leaves memory floating
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel_n <= 1'b1;
      wstrobe_n <= 1'b1;
      odrive_n <= 1'b1;
    end
    else
    begin
      sel_n <= !(state_nxt == ASRAM_RD || state_nxt == ASRAM_WR_SET
                 || state_nxt == ASRAM_WR);
      // strobe falls with select; data driven from the same edge
      wstrobe_n <= !(state_nxt == ASRAM_WR_SET || state_nxt == ASRAM_WR);
      odrive_n <= !(state_nxt == ASRAM_RD
                    || ((state_nxt == ASRAM_WR_SET || state_nxt == ASRAM_WR)
                        && oe_mode_nxt()));
    end
  end

  // data drive only in write states and hold cycle; never while reading
  always_ff @(posedge mclk)
  begin
    if (rst)
      shared_data_lines_oe_n <= 1'b1;
    else
      shared_data_lines_oe_n <= !(state_nxt == ASRAM_WR_SET || state_nxt == ASRAM_WR
                                  || state_nxt == ASRAM_WR_HOLD);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state_r == ASRAM_RD) && tif.done;
      if ((state_r == ASRAM_RD) && tif.done)
        rsp_rdata <= shared_data_lines_i;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      req_ready <= 1'b0;
    else
      req_ready <= (state_nxt == ASRAM_IDLE) && !(state_r == ASRAM_IDLE && take);
  end

  strobe_with_sel_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(wstrobe_n) |-> $fell(sel_n))
    else $error("write strobe fell apart from select");
  rd_no_wstrobe_a: assert property (@(posedge mclk) disable iff (rst)
    !sel_n && wstrobe_n |-> shared_data_lines_oe_n)
    else $error("data driven during read");
  contention_a: assert property (@(posedge mclk) disable iff (rst)
    !(!odrive_n && wstrobe_n && !sel_n && !shared_data_lines_oe_n))
    else $error("bus contention in read state");
  idle_float_a: assert property (@(posedge mclk) disable iff (rst)
    sel_n |-> wstrobe_n && odrive_n)
    else $error("strobe active while deselected");
  wr_strobe_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(wstrobe_n) |-> !sel_n && !shared_data_lines_oe_n)
    else $error("write strobe without select or data");
  wr_hold_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(wstrobe_n) |-> !shared_data_lines_oe_n)
    else $error("data released before strobe end");
  wr_width_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(wstrobe_n) |-> !wstrobe_n [*2])
    else $error("write pulse too short");
  rd_resp_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(sel_n) && wstrobe_n |-> ##[1:4] rsp_valid)
    else $error("read answer late");
  addr_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !sel_n && !$past(sel_n) |-> $stable(word_index))
    else $error("index moved during access");
  wr_width_oe_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(wstrobe_n) && !odrive_n |-> !wstrobe_n [*4])
    else $error("write pulse with output drive low too short");
  rd_drive_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ASRAM_RD) |-> !sel_n && !odrive_n && wstrobe_n)
    else $error("read state without select and output drive");
  idx_take_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(sel_n) |-> word_index == $past(req_index))
    else $error("index differs from taken request");
  rsp_data_a: assert property (@(posedge mclk) disable iff (rst)
    rsp_valid |-> rsp_rdata == $past(shared_data_lines_i))
    else $error("read word not taken from data lines");
  ready_idle_a: assert property (@(posedge mclk) disable iff (rst)
    req_ready |-> sel_n && shared_data_lines_oe_n)
    else $error("ready while memory still accessed");
  odrive_free_a: assert property (@(posedge mclk) disable iff (rst)
    !odrive_n |-> shared_data_lines_oe_n || !wstrobe_n)
    else $error("host drives data while memory may drive");
endmodule : asram_host

// ===== test/asram_mem_model.sv
// behavioural 256k x 4 asynchronous static memory facing the host
// assumes the host splits the data lines into output, enable and input
`timescale 1ns/1ps
module asram_mem_model
  import asram_pkg::*;
(
  input wire logic [ASRAM_IDX_W-1:0] word_index,
  input wire logic sel_n,
  input wire logic wstrobe_n,
  input wire logic odrive_n,
  input wire logic [ASRAM_DAT_W-1:0] host_data,
  input wire logic host_oe_n,
  output logic [ASRAM_DAT_W-1:0] dev_data
);
  logic [ASRAM_DAT_W-1:0] mem [int];
  logic [ASRAM_DAT_W-1:0] last_r = 4'h0;
  logic rd;
  assign rd = !sel_n && wstrobe_n && !odrive_n;
  // stores while select, strobe and host drive overlap; same-edge glitches can store
  always @*
    if (!sel_n && !wstrobe_n && !host_oe_n)
      mem[int'(word_index)] = host_data;
  always @*
  begin
    if (rd && mem.exists(int'(word_index)))
    begin
      dev_data = mem[int'(word_index)];
      last_r = dev_data;
    end
    else
      dev_data = ~last_r; // released lines show the inverted last read word
  end
endmodule : asram_mem_model

// ===== test/testbench.sv
// self-checking bench: host controller, memory model and reference array
// assumes the package constants and a 25 MHz clock
`timescale 1ns/1ps
module testbench;
  import asram_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_oe_low = 1'b0;
  logic [ASRAM_IDX_W-1:0] req_index = '0;
  logic [ASRAM_IDX_W-1:0] word_index, idx_q;
  logic [ASRAM_DAT_W-1:0] req_wdata = '0;
  logic [ASRAM_DAT_W-1:0] rsp_rdata, dq_o, dq_i, dev_data;
  logic req_ready, rsp_valid, sel_n, wstrobe_n, odrive_n, dq_oe_n;
  logic sel_q = 1'b1;
  logic [ASRAM_DAT_W-1:0] ref_mem [int];
  logic [ASRAM_IDX_W-1:0] idx_list [$];
  int err_count = 0;
  int n_tests = 0;

  assign dq_i = !dq_oe_n ? dq_o : dev_data;

  asram_host asram_host_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_oe_low(req_oe_low), .req_index(req_index),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .word_index(word_index), .sel_n(sel_n),
    .wstrobe_n(wstrobe_n), .odrive_n(odrive_n), .shared_data_lines_o(dq_o),
    .shared_data_lines_oe_n(dq_oe_n), .shared_data_lines_i(dq_i));

  asram_mem_model asram_mem_model_inst (.word_index(word_index), .sel_n(sel_n),
    .wstrobe_n(wstrobe_n), .odrive_n(odrive_n), .host_data(dq_o),
    .host_oe_n(dq_oe_n), .dev_data(dev_data));

  initial
    forever #(ASRAM_CLK_NS / 2) mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic issue(input logic w, input logic oel, input logic [17:0] i,
                       input logic [3:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_oe_low <= oel;
    req_index <= i;
    req_wdata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    chk(32'(req_ready), 32'h1);
    if (w)
    begin
      ref_mem[int'(i)] = d;
      @(posedge mclk);
    end
    else
    begin
      n = 0;
      do
      begin
        @(posedge mclk);
        n++;
      end
      while (rsp_valid !== 1'b1 && n < 50);
      chk(32'(rsp_valid), 32'h1);
      chk(32'(rsp_rdata), 32'(ref_mem[int'(i)]));
    end
  endtask : issue

  // bus ownership and index stability seen at the pins every cycle
  always @(posedge mclk)
    if (!rst)
    begin
      if (!sel_n && wstrobe_n && !odrive_n) chk(32'(dq_oe_n), 32'h1);
      if (!sel_q && !sel_n) chk(32'(word_index), 32'(idx_q));
      sel_q <= sel_n;
      idx_q <= word_index;
    end

  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'hf792));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    idx_list = '{18'h0, 18'h3FFFF};
    repeat (6) idx_list.push_back(18'($urandom_range(262143, 0)));
    foreach (idx_list[k]) issue(1'b1, k[0], idx_list[k], 4'($urandom));
    foreach (idx_list[k]) issue(1'b0, 1'b0, idx_list[k], 4'h0);
    issue(1'b1, 1'b1, 18'h3FFFF, 4'hA);
    issue(1'b0, 1'b0, 18'h3FFFF, 4'h0);
    print_verdict();
  end
endmodule : testbench
